// [verilog/tat_thermal_alarm_map.vh]
// Purpose: Register map, field positions and timing for the thermal alarm
// Assumes: 20 MHz core clock, 8-bit register port
// Notes:   Definitions only
`ifndef TAT_THERMAL_ALARM_MAP_VH
`define TAT_THERMAL_ALARM_MAP_VH

// ==========================================================
// Register offsets
`define TAT_REG_REMOTE1_LIMIT 8'h6a
`define TAT_REG_LOCAL_LIMIT 8'h6b
`define TAT_REG_REMOTE2_LIMIT 8'h6c
`define TAT_REG_INT_STATUS_TWO 8'h42
`define TAT_REG_INT_MASK_TWO 8'h75
`define TAT_REG_CONFIG_THREE 8'h78
`define TAT_REG_ASSERT_TIMER 8'h79
`define TAT_REG_TIMER_LIMIT 8'h7a
`define TAT_REG_CONFIG_FIVE 8'h7c
`define TAT_REG_CONFIG_FOUR 8'h7d

// ==========================================================
// Field positions
`define TAT_BIT_TIMER_FLAG 5
`define TAT_BIT_ALARM_ENABLE 1
`define TAT_BIT_FULL_SPEED 2
`define TAT_BIT_DRIVE_REMOTE1 5
`define TAT_BIT_DRIVE_LOCAL 6
`define TAT_BIT_DRIVE_REMOTE2 7
`define TAT_PIN_FUNC_THERMAL 2'h0
`define TAT_PIN_FUNC_TACH 2'h1
`define TAT_PIN_FUNC_GPIO 2'h2
`define TAT_PIN_FUNC_ALERT 2'h3

// ==========================================================
// Reset values
`define TAT_RST_LIMIT 8'h00
`define TAT_RST_MASK_TWO 8'h00
`define TAT_RST_CONFIG_THREE 8'h00
`define TAT_RST_CONFIG_FOUR 8'h01
`define TAT_RST_CONFIG_FIVE 8'h00
`define TAT_RST_TIMER 8'h00

// ==========================================================
// Limit values that switch a channel's drive off
`define TAT_LIMIT_OFF_OFFSET64 8'h00
`define TAT_LIMIT_OFF_TWOS 8'h80

// ==========================================================
// Timing
`define TAT_CLK_PERIOD_NS 50
`define TAT_STEP_TIME_NS 22760000
`define TAT_STEP_CYCLES (`TAT_STEP_TIME_NS / `TAT_CLK_PERIOD_NS)
`define TAT_TIMER_FULL 8'hff

`endif

// [verilog/tat_thermal_alarm.v]
// Purpose: Thermal alarm pin timer, limit flag, alert and pin drive
// Assumes: Register port driven by the serial interface on the same clock
// Notes:   Pin is open drain; output enable high pulls it low
`timescale 1ns/1ns
`default_nettype none
`include "tat_thermal_alarm_map.vh"

// Functional notes
// - Timer runs only while pin asserted
// - Assertion time accumulates across separate assertions
// - Reading timer returns value then clears it
// - Timer saturates at full scale until read
// - First assertion after clear sets bit 0
// - Past 45.52 ms bit 1 set, 22.76 ms steps
// - Read during assertion clears, sets bit 0, restarts
// - Zero limit read during assertion sets flag again
// - Eight-bit timer limit, zero up to 5.825 s
// - Timer above limit sets flag and alert
// - Mask bit 5 blocks alert, flag still set
// - Limit 0 alerts first assertion, 1 after 45.52 ms
// - Config three bit 1 enables pin function
// - Config five bits 5-7 enable per-channel drive
// - No drive enables means input only
// - External low assertions timed the same way
// - Full speed bit forces running fans 100 percent
// - Stopped fans are never started by alarm
// - Drive low when temperature exceeds limit 0.25 C
// - Stay low until temperature at or below limit
// - Channel limits at 0x6a, 0x6b, 0x6c
// - Minimum-code limit disables channel drive
// - Config four bits 1:0 select pin function
// - Status bits sticky until status register read
module tat_thermal_alarm #(
  parameter STEP_CYCLES = `TAT_STEP_CYCLES,
  parameter PRE_W = 20,
  parameter FANS = 4
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStrobe,
  input wire regRdStrobe,
  output reg [7:0] regRdData,
  // Shared alarm pin, open drain
  input wire thermalAlarmPinIn,
  output reg thermalAlarmPinOut,
  output reg thermalAlarmPinOe,
  // Temperatures, 8.2 fixed point, one update pulse per monitoring cycle
  input wire [9:0] tempRemote1,
  input wire [9:0] tempLocal,
  input wire [9:0] tempRemote2,
  input wire tempUpdate,
  input wire offset64Mode,
  // Fans
  input wire [FANS-1:0] fanRunning,
  output reg [FANS-1:0] fanFullSpeed,
  // Alert and pin function
  output reg smbAlertN,
  output reg [1:0] sharedPinFunction
);

  localparam integer STEP_LAST_INT = STEP_CYCLES - 1;
  localparam [PRE_W-1:0] STEP_LAST = STEP_LAST_INT[PRE_W-1:0];

  // ==========================================================
  // Limit comparison helpers
  function [8:0] orderKey;
    input [7:0] code;
    input twos;
    begin
      orderKey = {1'b0, code[7] ^ twos, code[6:0]};
    end
  endfunction

  function channelOff;
    input [7:0] limit;
    input off64;
    begin
      if (off64) begin
        channelOff = (limit == `TAT_LIMIT_OFF_OFFSET64);
      end else begin
        channelOff = (limit == `TAT_LIMIT_OFF_TWOS);
      end
    end
  endfunction

  // ==========================================================
  // Registers
  reg [7:0] remote1Limit;
  reg [7:0] localLimit;
  reg [7:0] remote2Limit;
  reg [7:0] intMaskTwo;
  reg [7:0] configThree;
  reg [7:0] configFour;
  reg [7:0] configFive;
  reg [7:0] timerLimit;
  reg [7:0] assertTimer;
  reg timerLimitFlag;
  reg halfStep;
  reg [PRE_W-1:0] preCount;
  reg pinSync1;
  reg pinSync2;
  reg [2:0] chanDrive;

  wire isWrite = regWrStrobe;
  wire readTimer = regRdStrobe && (regAddr == `TAT_REG_ASSERT_TIMER);
  wire readStatus = regRdStrobe && (regAddr == `TAT_REG_INT_STATUS_TWO);
  wire pinIsAlarm = (configFour[1:0] == `TAT_PIN_FUNC_THERMAL);
  wire alarmEnabled = configThree[`TAT_BIT_ALARM_ENABLE] && pinIsAlarm;
  // Pin level seen after the synchroniser, whoever pulls it
  wire pinAsserted = alarmEnabled && !pinSync2;
  wire stepTick = pinAsserted && (preCount == STEP_LAST);
  wire [7:0] statusTwo = {2'h0, timerLimitFlag, 5'h00};

  // ==========================================================
  // Pin synchroniser
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
    end else begin
      pinSync1 <= thermalAlarmPinIn;
      pinSync2 <= pinSync1;
    end
  end

  // ==========================================================
  // Writable registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote1Limit <= `TAT_RST_LIMIT;
      localLimit <= `TAT_RST_LIMIT;
      remote2Limit <= `TAT_RST_LIMIT;
      intMaskTwo <= `TAT_RST_MASK_TWO;
      configThree <= `TAT_RST_CONFIG_THREE;
      configFour <= `TAT_RST_CONFIG_FOUR;
      configFive <= `TAT_RST_CONFIG_FIVE;
      timerLimit <= `TAT_RST_LIMIT;
    end else if (isWrite) begin
      case (regAddr)
        `TAT_REG_REMOTE1_LIMIT: remote1Limit <= regWrData;
        `TAT_REG_LOCAL_LIMIT: localLimit <= regWrData;
        `TAT_REG_REMOTE2_LIMIT: remote2Limit <= regWrData;
        `TAT_REG_INT_MASK_TWO: intMaskTwo <= regWrData;
        `TAT_REG_CONFIG_THREE: configThree <= regWrData;
        `TAT_REG_CONFIG_FOUR: configFour <= regWrData;
        `TAT_REG_CONFIG_FIVE: configFive <= regWrData;
        `TAT_REG_TIMER_LIMIT: timerLimit <= regWrData;
        default: remote1Limit <= remote1Limit;
      endcase
    end
  end

  // ==========================================================
  // Prescaler: keeps its partial step across assertions
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      preCount <= {PRE_W{1'b0}};
    end else if (readTimer) begin
      preCount <= {PRE_W{1'b0}};
    end else if (stepTick) begin
      preCount <= {PRE_W{1'b0}};
    end else if (pinAsserted) begin
      preCount <= preCount + 1'b1;
    end
  end

  // ==========================================================
  // Assertion timer
  // Value 1 marks first assertion; two steps later the count reads 2
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      assertTimer <= `TAT_RST_TIMER;
      halfStep <= 1'b0;
    end else if (readTimer) begin
      halfStep <= 1'b0;
      if (pinAsserted) begin
        assertTimer <= 8'h01;
      end else begin
        assertTimer <= `TAT_RST_TIMER;
      end
    end else if (pinAsserted) begin
      if (assertTimer == `TAT_RST_TIMER) begin
        assertTimer <= 8'h01;
      end else if (stepTick) begin
        if (assertTimer == 8'h01 && !halfStep) begin
          halfStep <= 1'b1;
        end else if (assertTimer == 8'h01) begin
          assertTimer <= 8'h02;
        end else if (assertTimer != `TAT_TIMER_FULL) begin
          assertTimer <= assertTimer + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Limit flag: set wins over the clearing read
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timerLimitFlag <= 1'b0;
    end else if (assertTimer > timerLimit) begin
      timerLimitFlag <= 1'b1;
    end else if (readStatus) begin
      timerLimitFlag <= 1'b0;
    end
  end

  // ==========================================================
  // Alert output, active low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      smbAlertN <= 1'b1;
    end else begin
      smbAlertN <= !(timerLimitFlag &&
        !intMaskTwo[`TAT_BIT_TIMER_FLAG]);
    end
  end

  // ==========================================================
  // Per-channel overtemperature drive, judged once per monitoring cycle
  wire [9:0] chanTemp [0:2];
  wire [7:0] chanLimit [0:2];
  assign chanTemp[0] = tempRemote1;
  assign chanTemp[1] = tempLocal;
  assign chanTemp[2] = tempRemote2;
  assign chanLimit[0] = remote1Limit;
  assign chanLimit[1] = localLimit;
  assign chanLimit[2] = remote2Limit;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : gChan
      wire [10:0] tKey = {orderKey(chanTemp[ch][9:2], !offset64Mode),
        chanTemp[ch][1:0]};
      wire [10:0] lKey = {orderKey(chanLimit[ch], !offset64Mode), 2'h0};
      wire allowed = configFive[`TAT_BIT_DRIVE_REMOTE1 + ch] &&
        !channelOff(chanLimit[ch], offset64Mode);
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          chanDrive[ch] <= 1'b0;
        end else if (!allowed) begin
          chanDrive[ch] <= 1'b0;
        end else if (tempUpdate) begin
          // Strictly above means at least a quarter degree over
          chanDrive[ch] <= (tKey > lKey);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Pin drive and fan full_speed_on_alarm
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      thermalAlarmPinOut <= 1'b0;
      thermalAlarmPinOe <= 1'b0;
      fanFullSpeed <= {FANS{1'b0}};
      sharedPinFunction <= `TAT_PIN_FUNC_TACH;
    end else begin
      thermalAlarmPinOut <= 1'b0;
      thermalAlarmPinOe <= alarmEnabled && (|chanDrive);
      if (configThree[`TAT_BIT_FULL_SPEED] && pinAsserted) begin
        fanFullSpeed <= fanRunning;
      end else begin
        fanFullSpeed <= {FANS{1'b0}};
      end
      sharedPinFunction <= configFour[1:0];
    end
  end

  // ==========================================================
  // Read data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else if (regRdStrobe) begin
      case (regAddr)
        `TAT_REG_REMOTE1_LIMIT: regRdData <= remote1Limit;
        `TAT_REG_LOCAL_LIMIT: regRdData <= localLimit;
        `TAT_REG_REMOTE2_LIMIT: regRdData <= remote2Limit;
        `TAT_REG_INT_STATUS_TWO: regRdData <= statusTwo;
        `TAT_REG_INT_MASK_TWO: regRdData <= intMaskTwo;
        `TAT_REG_CONFIG_THREE: regRdData <= configThree;
        `TAT_REG_CONFIG_FOUR: regRdData <= configFour;
        `TAT_REG_CONFIG_FIVE: regRdData <= configFive;
        `TAT_REG_TIMER_LIMIT: regRdData <= timerLimit;
        `TAT_REG_ASSERT_TIMER: regRdData <= assertTimer;
        default: regRdData <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// [dv/tat_thermal_alarm_assertions.sv]
// Purpose: Port assertions for the thermal alarm block
// Assumes: Register writes are visible on the port
// Notes: Config registers shadowed in helper logic
`timescale 1ns/1ns
`default_nettype none
module tat_thermal_alarm_assertions #(
  parameter FANS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [7:0] regRdData,
  // Pin, fans and alert
  input wire logic thermalAlarmPinIn,
  input wire logic thermalAlarmPinOut,
  input wire logic thermalAlarmPinOe,
  input wire logic [FANS-1:0] fanRunning,
  input wire logic [FANS-1:0] fanFullSpeed,
  input wire logic smbAlertN,
  input wire logic [1:0] sharedPinFunction
);
  logic [7:0] cfg3, cfg4, cfg5, mask, pinHist;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg3 <= 8'h00;
      cfg4 <= 8'h01;
      cfg5 <= 8'h00;
      mask <= 8'h00;
      pinHist <= 8'hff;
    end else begin
      pinHist <= {pinHist[6:0], thermalAlarmPinIn};
      if (regWrStrobe && regAddr == 8'h78) cfg3 <= regWrData;
      if (regWrStrobe && regAddr == 8'h7d) cfg4 <= regWrData;
      if (regWrStrobe && regAddr == 8'h7c) cfg5 <= regWrData;
      if (regWrStrobe && regAddr == 8'h75) mask <= regWrData;
    end
  end
  chk_out_zero: assert property (!thermalAlarmPinOut)
    else $error("pin output not zero");
  chk_input_only: assert property (cfg5[7:5] == 3'h0 &&
    $past(cfg5[7:5]) == 3'h0 && $past(cfg5[7:5], 2) == 3'h0
    |-> !thermalAlarmPinOe) else $error("pin driven as input");
  chk_full_speed_on_alarm_idle: assert property (!cfg3[2] && !$past(cfg3[2])
    |-> fanFullSpeed == '0) else $error("full_speed_on_alarm without enable");
  chk_full_speed_on_alarm_running: assert property (
    (fanFullSpeed & ~$past(fanRunning)) == '0)
    else $error("stopped fan boosted");
  chk_func_copy: assert property (regWrStrobe &&
    regAddr == 8'h7d |-> ##2 sharedPinFunction == $past(regWrData[1:0], 2))
    else $error("pin function not updated");
  chk_mask_quiet: assert property ($fell(smbAlertN)
    |-> !$past(mask[5])) else $error("masked alert raised");
  chk_drive_enable: assert property ($rose(thermalAlarmPinOe)
    |-> cfg3[1] && cfg4[1:0] == 2'b00 && cfg5[7:5] != 3'h0)
    else $error("pin driven while disabled");
  chk_read_clear: assert property (regRdStrobe &&
    regAddr == 8'h79 && &pinHist && $past(regRdStrobe, 2) &&
    $past(regAddr, 2) == 8'h79 |=> regRdData == 8'h00)
    else $error("timer not cleared by read");
endmodule
bind tat_thermal_alarm tat_thermal_alarm_assertions #(.FANS(FANS)) i_chk (
  .clk, .resetn, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe,
  .regRdData, .thermalAlarmPinIn, .thermalAlarmPinOut, .thermalAlarmPinOe,
  .fanRunning, .fanFullSpeed, .smbAlertN, .sharedPinFunction);
`default_nettype wire

// [dv/tat_pin_partner.sv]
// Purpose: Outside party on the shared alarm pin
// Assumes: Pin has a pull-up, both sides open drain
// Notes: Pulls low one cycle after holdLow rises
`timescale 1ns/1ns
`default_nettype none
module tat_pin_partner (
  // Clock
  input wire logic clk,
  // Control and pin
  input wire logic holdLow,
  input wire logic dutOe,
  output logic pinLevel
);
  logic extLow = 1'b0;
  always @(posedge clk) extLow <= holdLow;
  assign pinLevel = !(extLow || dutOe);
endmodule
`default_nettype wire

// [dv/tb_tat_thermal_alarm.sv]
// Purpose: Self-checking bench for the thermal alarm block
// Assumes: Step shortened to 8 cycles
// Notes: Reads queue expected data for the monitor
`timescale 1ns/1ns
`default_nettype none
module tb_tat_thermal_alarm;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [9:0] tR1 = 10'h000, tLoc = 10'h000, tR2 = 10'h000;
  logic tempUpdate = 1'b0;
  logic [3:0] fanRunning = 4'h0, upCnt = 4'h0, fanFull;
  logic holdLow = 1'b0, rdSeen = 1'b0, pin, oe, pinOut, alertN;
  logic [7:0] rdData, lim;
  logic [1:0] pinFunc;
  logic [7:0] expQ[$];
  int err_count = 0;
  int tests_run = 0;
  tat_thermal_alarm #(.STEP_CYCLES(8)) i_dut (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(rdData), .thermalAlarmPinIn(pin),
    .thermalAlarmPinOut(pinOut), .thermalAlarmPinOe(oe), .tempRemote1(tR1),
    .tempLocal(tLoc), .tempRemote2(tR2), .tempUpdate(tempUpdate),
    .offset64Mode(1'b0), .fanRunning(fanRunning), .fanFullSpeed(fanFull),
    .smbAlertN(alertN), .sharedPinFunction(pinFunc));
  tat_pin_partner i_partner (.clk(clk), .holdLow(holdLow), .dutOe(oe),
    .pinLevel(pin));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    upCnt <= upCnt + 4'h1;
    tempUpdate <= (upCnt == 4'h7);
    rdSeen <= regRdStrobe;
  end
  always @(negedge clk) if (rdSeen) chk(rdData, expQ.pop_front());
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
  endtask
  task low(input int n);
    @(posedge clk);
    holdLow <= 1'b1;
    repeat (n) @(posedge clk);
    holdLow <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(10000 * 50);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(61485));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h7d, 8'h01);
    rd(8'h7a, 8'h00);
    $display("reset test done");
    wr(8'h7d, 8'h00);
    wr(8'h78, 8'h02);
    wr(8'h7a, 8'h01);
    low(20);
    low(16);
    chk({7'h0, alertN}, 8'h00);
    rd(8'h79, 8'h04);
    rd(8'h79, 8'h00);
    rd(8'h42, 8'h20);
    rd(8'h42, 8'h00);
    $display("accumulate test done");
    wr(8'h7a, 8'h00);
    wr(8'h78, 8'h06);
    fanRunning <= 4'($urandom) | 4'h1;
    holdLow <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h79, 8'h01);
    rd(8'h79, 8'h01);
    rd(8'h42, 8'h20);
    chk({4'h0, fanFull}, {4'h0, fanRunning});
    holdLow <= 1'b0;
    repeat (8) @(posedge clk);
    chk({4'h0, fanFull}, 8'h00);
    rd(8'h79, 8'h01);
    rd(8'h42, 8'h20);
    low(2100);
    rd(8'h79, 8'hff);
    rd(8'h42, 8'h20);
    $display("read and saturate test done");
    wr(8'h75, 8'h20);
    low(4);
    chk({7'h0, alertN}, 8'h01);
    rd(8'h79, 8'h01);
    rd(8'h42, 8'h20);
    wr(8'h75, 8'h00);
    $display("mask test done");
    lim = 8'h10 + 8'($urandom_range(0, 63));
    for (int i = 0; i < 3; i++) wr(8'h6a + 8'(i), lim);
    tR1 <= {lim, 2'b01};
    tLoc <= {lim, 2'b01};
    tR2 <= {lim, 2'b01};
    for (int i = 0; i < 3; i++) begin
      wr(8'h7c, 8'h20 << i);
      repeat (40) @(posedge clk);
      chk({7'h0, oe}, 8'h01);
    end
    wr(8'h7c, 8'h00);
    repeat (4) @(posedge clk);
    chk({7'h0, oe}, 8'h00);
    wr(8'h7c, 8'h20);
    repeat (40) @(posedge clk);
    chk({7'h0, oe}, 8'h01);
    tR1 <= {lim, 2'b00};
    repeat (40) @(posedge clk);
    chk({7'h0, oe}, 8'h00);
    tR1 <= {8'h7f, 2'b00};
    wr(8'h6a, 8'h80);
    repeat (40) @(posedge clk);
    chk({7'h0, oe}, 8'h00);
    $display("drive test done");
    conclude();
  end
endmodule
`default_nettype wire
